/* design/scc_regs.svh */
// Purpose: Timing constants for the supply cut controller
// Assumes: 10 MHz system clock
// Notes:   Counts are derived from the printed times
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

`define SCC_CLK_MHZ        10
`define SCC_DEB_NS         1000
`define SCC_DEB_CYC        ((`SCC_DEB_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_NEG_HOLD_S     30
`define SCC_NEG_HOLD_CYC   (`SCC_NEG_HOLD_S * `SCC_CLK_MHZ * 1000000)
`define SCC_HOLD_W         29
`define SCC_DEB_W          8
`define SCC_RST_SUPPORTED  1'b1

`endif

/* design/scc_pkg.sv */
// Purpose: State types for the supply cut controller
// Assumes: Widths come from scc_regs.svh
// Notes:   One packed struct per module
`include "scc_regs.svh"

package scc_pkg;

    typedef logic [`SCC_HOLD_W-1:0] scc_hold_t;
    typedef logic [`SCC_DEB_W-1:0]  scc_deb_t;

    typedef struct packed {
        logic     s1;
        logic     s2;
        logic     lvl;
        scc_deb_t cnt;
    } scc_filt_st_t;

    typedef struct packed {
        logic      lvl_q;
        logic      cut;
        logic      power_en;
        logic      por;
        logic      sup_vpd;
        logic      sup_frame;
        logic      met;
        scc_hold_t cnt;
    } scc_top_st_t;

endpackage : scc_pkg

/* design/scc_if.sv */
// Purpose: Carries the qualified supply cut level
// Assumes: Single clock domain
// Notes:   Driven by the filter, read by the controller
`timescale 1ns/100ps

interface scc_if;
    logic lvl;
    modport filt (output lvl);
    modport ctrl (input  lvl);
endinterface : scc_if

/* design/scc_filter.sv */
// Purpose: Synchroniser and debounce for the supply cut input
// Assumes: DEB_CYC fits in the debounce counter
// Notes:   Level passes only after DEB_CYC steady cycles
`timescale 1ns/100ps

module scc_filter
    import scc_pkg::*;
#(
    parameter int unsigned DEB_CYC = `SCC_DEB_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    scc_if.filt       f
);

    scc_filt_st_t s;
    scc_filt_st_t next_s;

    localparam scc_deb_t DEB_LAST = scc_deb_t'(DEB_CYC - 1);

    always_comb begin
        next_s    = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
        if (s.s2 == s.lvl) begin
            next_s.cnt = '0;
        end else if (s.cnt == DEB_LAST) begin
            next_s.lvl = s.s2;
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    // Negated at reset so power comes up before the input is known
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign f.lvl = s.lvl;

    // Counter at its last step stands in for a long repetition of steady samples
    sequence s_new_level;
        s.s2 != s.lvl && s.cnt == DEB_LAST;
    endsequence

    property p_deb_pass;
        @(posedge clk) disable iff (!rst_n) s_new_level |=> $changed(s.lvl);
    endproperty
    a_deb_pass: assert property (p_deb_pass)
        else $error("Steady new level not passed after debounce");

    property p_deb_block;
        @(posedge clk) disable iff (!rst_n)
            $changed(s.lvl) |-> $past(s.cnt) == DEB_LAST && s.lvl == $past(s.s2);
    endproperty
    a_deb_block: assert property (p_deb_block)
        else $error("Level changed before debounce time");

    property p_sync;
        @(posedge clk) disable iff (!rst_n) ##2 (s.s2 == $past(raw, 2));
    endproperty
    a_sync: assert property (p_sync)
        else $error("Synchroniser is not two stages");

endmodule : scc_filter

/* design/scc_top.sv */
// Purpose: Gates target power from the supply cut input
// Assumes: Reset is the power-on reset of the target
// Notes:   Hold time is measured on the debounced level
`timescale 1ns/100ps

// Notes on behaviour
// - Power stays on while input negated
// - Qualified assertion removes power
// - Release after qualified cut starts power-on
// - Level changes need one microsecond steady
// - Support flagged for VPD and identify frame
// - Unconnected contact keeps power on
// - Cut and restore latency is DEB_CYC + 3 cycles from supply_cut
module scc_top
    import scc_pkg::*;
#(
    parameter int unsigned DEB_CYC      = `SCC_DEB_CYC,
    parameter int unsigned NEG_HOLD_CYC = `SCC_NEG_HOLD_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supply_cut,
    input  wire logic cut_wired,
    output logic      power_en,
    output logic      power_on_start,
    output logic      hold_met,
    output logic      sup_vpd,
    output logic      sup_frame
);

    scc_top_st_t s;
    scc_top_st_t next_s;
    logic        eff;
    logic        rise;
    logic        fall;

    localparam scc_hold_t HOLD = scc_hold_t'(NEG_HOLD_CYC);

    scc_if u_lvl ();

    scc_filter #(
        .DEB_CYC (DEB_CYC)
    ) u_filter (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (supply_cut),
        .f     (u_lvl.filt)
    );

    // An open contact reads as negated
    assign eff  = cut_wired & u_lvl.lvl;
    assign rise = eff & ~s.lvl_q;
    assign fall = ~eff & s.lvl_q;

    always_comb begin
        next_s       = s;
        next_s.lvl_q = eff;
        next_s.por   = 1'b0;
        if (rise) begin
            // Unqualified assertions are ignored, power stays on
            next_s.cut = (s.cnt == HOLD);
            next_s.cnt = '0;
        end else if (fall) begin
            if (s.cut) begin
                next_s.cut = 1'b0;
                next_s.por = 1'b1;
            end
        end else if (!eff && s.cnt != HOLD) begin
            // Counting from reset covers the hold after power-up
            next_s.cnt = s.cnt + 29'h0000001;
        end
        next_s.power_en = ~next_s.cut;
        next_s.met      = (next_s.cnt == HOLD);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s           <= '0;
            s.power_en  <= 1'b1;
            s.sup_vpd   <= `SCC_RST_SUPPORTED;
            s.sup_frame <= `SCC_RST_SUPPORTED;
        end else begin
            s <= next_s;
        end
    end

    assign power_en       = s.power_en;
    assign power_on_start = s.por;
    assign hold_met       = s.met;
    assign sup_vpd        = s.sup_vpd;
    assign sup_frame      = s.sup_frame;

    sequence s_qual_rise;
        eff && !s.lvl_q && s.cnt == HOLD;
    endsequence

    sequence s_cut_release;
        !eff && s.lvl_q && s.cut;
    endsequence

    property p_neg_on;
        @(posedge clk) disable iff (!rst_n) (!eff && !s.lvl_q) [*2] |-> s.power_en;
    endproperty
    a_neg_on: assert property (p_neg_on)
        else $error("Power off while input negated");

    property p_cut;
        @(posedge clk) disable iff (!rst_n) s_qual_rise |=> !s.power_en;
    endproperty
    a_cut: assert property (p_cut)
        else $error("Qualified assertion did not cut power");

    property p_unqual;
        @(posedge clk) disable iff (!rst_n)
            (eff && !s.lvl_q && s.cnt != HOLD) |=> s.power_en;
    endproperty
    a_unqual: assert property (p_unqual)
        else $error("Assertion before hold time cut power");

    property p_por;
        @(posedge clk) disable iff (!rst_n)
            s_cut_release |=> (s.por && s.power_en) ##1 !s.por;
    endproperty
    a_por: assert property (p_por)
        else $error("Power-on start missing after release");

    property p_por_cause;
        @(posedge clk) disable iff (!rst_n) s.por |-> $past(s.cut) && !s.cut;
    endproperty
    a_por_cause: assert property (p_por_cause)
        else $error("Power-on start without prior cut");

    property p_support;
        @(posedge clk) disable iff (!rst_n) s.sup_vpd && s.sup_frame;
    endproperty
    a_support: assert property (p_support)
        else $error("Support flags not reported");

    property p_open;
        @(posedge clk) disable iff (!rst_n) (!cut_wired) [*2] |=> s.power_en;
    endproperty
    a_open: assert property (p_open)
        else $error("Open contact did not keep power on");

    property p_latency;
        @(posedge clk) disable iff (!rst_n)
            $fell(s.power_en) |-> $past(rise) && $past(s.cnt) == HOLD;
    endproperty
    a_latency: assert property (p_latency)
        else $error("Power cut without qualified assertion");

    // Counter checks guard the negated hold against off-by-one slips
    sequence s_neg_steady;
        !eff && !s.lvl_q;
    endsequence

    sequence s_held_asserted;
        eff && s.lvl_q;
    endsequence

    property p_hold_sat;
        @(posedge clk) disable iff (!rst_n) s.cnt <= HOLD;
    endproperty
    a_hold_sat: assert property (p_hold_sat)
        else $error("Hold counter ran past its limit");

    property p_hold_clear;
        @(posedge clk) disable iff (!rst_n) (eff && !s.lvl_q) |=> s.cnt == '0;
    endproperty
    a_hold_clear: assert property (p_hold_clear)
        else $error("Hold counter not cleared by assertion");

    property p_hold_count;
        @(posedge clk) disable iff (!rst_n)
            s_neg_steady ##0 (s.cnt != HOLD) |=> s.cnt == $past(s.cnt) + 29'h0000001;
    endproperty
    a_hold_count: assert property (p_hold_count)
        else $error("Hold counter did not advance while negated");

    property p_asserted_zero;
        @(posedge clk) disable iff (!rst_n) s_held_asserted |-> s.cnt == '0;
    endproperty
    a_asserted_zero: assert property (p_asserted_zero)
        else $error("Hold counter moved while asserted");

    property p_met_flag;
        @(posedge clk) disable iff (!rst_n) s.met == (s.cnt == HOLD);
    endproperty
    a_met_flag: assert property (p_met_flag)
        else $error("Hold met flag disagrees with counter");

    property p_cut_hold;
        @(posedge clk) disable iff (!rst_n) s_held_asserted ##0 s.cut |=> !s.power_en;
    endproperty
    a_cut_hold: assert property (p_cut_hold)
        else $error("Power returned while input still asserted");

    property p_por_pulse;
        @(posedge clk) disable iff (!rst_n) s.por |=> !s.por;
    endproperty
    a_por_pulse: assert property (p_por_pulse)
        else $error("Power-on start longer than one cycle");

    property p_no_por_unqual;
        @(posedge clk) disable iff (!rst_n) (fall && !s.cut) |=> !s.por;
    endproperty
    a_no_por_unqual: assert property (p_no_por_unqual)
        else $error("Power-on start after unqualified release");

    property p_power_tracks;
        @(posedge clk) disable iff (!rst_n) s.power_en == !s.cut;
    endproperty
    a_power_tracks: assert property (p_power_tracks)
        else $error("Power enable disagrees with cut state");

    property p_lvl_track;
        @(posedge clk) disable iff (!rst_n) s.lvl_q == $past(eff);
    endproperty
    a_lvl_track: assert property (p_lvl_track)
        else $error("Edge detector not one cycle behind level");

endmodule : scc_top

/* verification/scc_encl_model.sv */
// Purpose: Enclosure side driver of the supply cut input
// Assumes: Hold times given in clock cycles
// Notes:   early lets a scenario break the hold times on purpose
`timescale 1ns/100ps

module scc_encl_model #(
    parameter int unsigned ASSERT_HOLD = 20,
    parameter int unsigned NEG_HOLD    = 56
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic want_cut,
    input  wire logic early,
    output logic      supply_cut
);
    int unsigned held;

    // Both levels driven, never left open; hold counted from power-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_cut <= 1'b0;
            held       <= 0;
        end else if (want_cut != supply_cut &&
                     (early || held >= (supply_cut ? ASSERT_HOLD : NEG_HOLD))) begin
            supply_cut <= want_cut;
            held       <= 0;
        end else if (held < NEG_HOLD) begin
            held <= held + 1;
        end
    end
endmodule : scc_encl_model

/* verification/tb_supply_cut_control.sv */
// Purpose: Self-checking bench for the supply cut controller
// Assumes: Short hold count, debounce kept at ten cycles
// Notes:   Driver hold margin avoids a borderline qualification
`timescale 1ns/100ps

module tb_supply_cut_control;
    localparam int unsigned DEB = 10;
    localparam int unsigned NEG = 50;
    logic clk = 0, rst_n = 0, cut_wired = 1, want_cut = 0, early = 0;
    logic supply_cut, power_en, power_on_start, hold_met, sup_vpd, sup_frame;
    int   mismatches = 0, n_compared = 0, pos_cnt = 0, n;

    always #50 clk = ~clk;
    always @(posedge clk) if (power_on_start === 1'b1) pos_cnt++;

    scc_top #(.DEB_CYC(DEB), .NEG_HOLD_CYC(NEG)) dut (
        .clk(clk), .rst_n(rst_n), .supply_cut(supply_cut), .cut_wired(cut_wired),
        .power_en(power_en), .power_on_start(power_on_start), .hold_met(hold_met),
        .sup_vpd(sup_vpd), .sup_frame(sup_frame));
    scc_encl_model #(.ASSERT_HOLD(20), .NEG_HOLD(NEG + 6)) encl (
        .clk(clk), .rst_n(rst_n), .want_cut(want_cut), .early(early),
        .supply_cut(supply_cut));

    task automatic end_sim;
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic drive(input logic lvl, input logic pe, output int m);
        want_cut = lvl;
        for (int k = 0; k < 200 && supply_cut !== lvl; k++) tick(1);
        m = 0;
        while (power_en !== pe && m < 40) begin
            tick(1);
            m++;
        end
    endtask : drive

    task automatic wait_hold;
        for (int k = 0; k < 200 && hold_met !== 1'b1; k++) tick(1);
        chk("hold_met", hold_met, 1);
    endtask : wait_hold

    task automatic t_reset;
        chk("power_en", power_en, 1);
        chk("power_on_start", power_on_start, 0);
        chk("hold_met", hold_met, 0);
        chk("sup_vpd", sup_vpd, 1);
        chk("sup_frame", sup_frame, 1);
    endtask : t_reset

    // Assertion before the hold time is met must not cut
    task automatic t_early;
        early = 1;
        drive(1, 1, n);
        tick(30);
        chk("power_en", power_en, 1);
        chk("hold_met", hold_met, 0);
        drive(0, 1, n);
        tick(30);
        chk("pos_cnt", pos_cnt, 0);
        early = 0;
    endtask : t_early

    // Nine cycle pulse, one short of the debounce span
    task automatic t_glitch;
        wait_hold();
        early = 1;
        want_cut = 1;
        tick(9);
        want_cut = 0;
        tick(30);
        chk("power_en", power_en, 1);
        chk("hold_met", hold_met, 1);
        chk("pos_cnt", pos_cnt, 0);
        early = 0;
    endtask : t_glitch

    // Two sync stages, DEB steady samples, then one register stage
    task automatic t_cut;
        drive(1, 0, n);
        chk("cut_latency", n, DEB + 3);
        chk("hold_met", hold_met, 0);
        drive(0, 1, n);
        chk("restore_latency", n, DEB + 3);
        chk("power_on_start", power_on_start, 1);
        tick(1);
        chk("power_on_start", power_on_start, 0);
        chk("pos_cnt", pos_cnt, 1);
    endtask : t_cut

    task automatic t_unwired;
        wait_hold();
        cut_wired = 0;
        drive(1, 1, n);
        tick(30);
        chk("power_en", power_en, 1);
        drive(0, 1, n);
        // Reconnect only once the filtered level is negated again
        tick(20);
        cut_wired = 1;
        tick(30);
        chk("power_en", power_en, 1);
        chk("pos_cnt", pos_cnt, 1);
    endtask : t_unwired

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        tick(1);
        t_reset();
        t_early();
        t_glitch();
        t_cut();
        t_unwired();
        end_sim();
    end
endmodule : tb_supply_cut_control
